// ===== hdl/tirq_pkg.sv
// Shared constants, register map and carrier types of the timer event-request block
package tirq_pkg;

    // Sizes
    localparam int NCH      = 5;           // Timer channels
    localparam int SRC_W    = 6;           // Source bits per channel: A B C D overflow underflow
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 16;
    localparam int N_STORE  = 19;          // Protected registers held here besides two enable regs
    localparam int N_PROT   = 21;          // Whole protected set, enable regs of ch3/ch4 included
    localparam int N_BUF    = 4;           // Buffer registers, never protected
    localparam int N_SHUT   = 4;           // External shutdown inputs
    localparam int N_PWM    = 6;           // Complementary PWM output pins

    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS   = 8'h00;   // Status of channel c at +4*c
    localparam logic [7:0] ADDR_ENABLE   = 8'h20;   // Enable of channel c at +4*c
    localparam logic [7:0] ADDR_ACCESS   = 8'h40;   // Port timer write-enable register
    localparam logic [7:0] ADDR_EVT_STAT = 8'h44;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h48;
    localparam logic [7:0] ADDR_SHUTDOWN = 8'h4C;
    localparam logic [7:0] ADDR_PROT     = 8'h80;   // Protected store k at +4*k
    localparam logic [7:0] ADDR_BUF      = 8'hE0;   // Buffer k at +4*k

    // Field positions
    localparam int BIT_CMP_A   = 0;
    localparam int BIT_OVF     = 4;
    localparam int BIT_UNF     = 5;
    localparam int BIT_DMA_SEL = 6;
    localparam int BIT_ADC_EN  = 7;
    localparam int BIT_ACC_EN  = 0;
    localparam int EVT_SHUT    = 0;
    localparam int EVT_REFUSED = 1;
    localparam int EVT_W       = 2;

    // Which sources exist, channel 4 in the top six bits
    localparam logic [NCH*SRC_W-1:0] SRC_PRESENT = {6'h1F, 6'h1F, 6'h33, 6'h33, 6'h1F};

    // Values after reset and fixed answers
    localparam logic              ACC_EN_RST  = 1'b1;
    localparam logic [7:0]        ENABLE_RST  = 8'h00;
    localparam logic [DATA_W-1:0] STORE_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] UNDEF_READ  = 16'hFFFF;  // Returned for locked reads
    localparam logic              SHUT_ACTIVE = 1'b0;      // Shutdown inputs act when low

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tirq_bus_t;

    // One channel's sources, laid out as the status register
    typedef struct packed {
        logic       unf;
        logic       ovf;
        logic [3:0] cmp;
    } tirq_src_t;

endpackage

// ===== hdl/tirq_sync3.sv
// Three-stage synchroniser for pin inputs, change taken once stages two and three agree
`timescale 1ns/100ps
module tirq_sync3 #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Chain resets to the idle level of the pins (high)
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '1;
            s2   <= '1;
            s3   <= '1;
        end else begin
            meta <= din;
            s2   <= meta;
            s3   <= s2;
        end
    end

    // Filter: a single-cycle glitch between stages never reaches the output
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dout <= '1;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule

// ===== hdl/tirq_flag_cell.sv
// One status flag: hardware set, read-then-write-zero clear, optional DMA clear
`timescale 1ns/100ps
module tirq_flag_cell (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic set,
    input  wire logic rd_one,
    input  wire logic wr_zero,
    input  wire logic hw_clr,
    output logic      flag
);
    logic armed;
    logic clr;

    // A zero write clears only after the flag was read as one
    assign clr = (wr_zero & armed) | hw_clr;

    // Set wins over any clear in the same cycle so no event is lost
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end

    // Arming is dropped once the flag has gone, so a stale read cannot clear a new event
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (clr || !flag) begin
            armed <= 1'b0;
        end else if (rd_one) begin
            armed <= 1'b1;
        end
    end
endmodule

// ===== hdl/tirq_top.sv
// Timer event flags, interrupt/DMA/ADC requests, register protection and PWM shutdown
//
// Contract
// - One access-enable bit gates protected registers
// - Protected set is exactly twenty-one registers
// - Buffer registers always writable
// - Locked reads undefined, locked writes dropped
// - Any shutdown input forces PWM pins off
// - Every source has own flag and enable
// - Event sets flag; flag and enable request
// - Request withdrawn only by flag clear (code also drops it when the enable bit is cleared)
// - Fixed priority: A, B, C, D, overflow/underflow
// - Sixteen compare sources over five channels
// - One overflow flag per channel
// - Underflow only on channels one and two
// - Channel four wraps both into overflow
// - Compare-A flag plus select requests DMA
// - DMA service clears compare-A flag
// - Compare-A flag plus enable starts conversion
// - Zero write clears only after reading one
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
module tirq_top
    import tirq_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    input  wire tirq_pkg::tirq_bus_t         bus,
    output logic [tirq_pkg::DATA_W-1:0]      rdata,
    input  wire tirq_pkg::tirq_src_t [4:0]   src_evt,
    input  wire logic [tirq_pkg::NCH-1:0]    dma_ack,
    input  wire logic [tirq_pkg::N_SHUT-1:0] shutdown_pin,
    output tirq_pkg::tirq_src_t [4:0]        irq_req,
    output logic                             irq_any,
    output logic [4:0]                       irq_top_id,
    output logic [tirq_pkg::NCH-1:0]         dma_req,
    output logic [tirq_pkg::NCH-1:0]         adc_start,
    output logic [tirq_pkg::N_PWM-1:0]       pwm_hiz,
    output logic                             evt_irq
);
    import tirq_pkg::*;

    // Elaboration check: the map and the priority index assume this shape
    if (NCH != 5 || SRC_W != 6 || N_STORE + 2 != N_PROT) begin : g_bad_shape
        $error("tirq_top: unsupported channel layout");
    end

    // Word hit in a table of registers spaced by four bytes
    function automatic logic word_hit(input logic [7:0] a, input logic [7:0] base, input int idx);
        word_hit = (a == 8'(base + 8'(idx * 4)));
    endfunction

    // Index of a word inside a table, valid only when in_table says so
    function automatic logic [4:0] word_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] diff;
        diff     = 8'(a - base);
        word_idx = diff[6:2];
    endfunction

    // True when the address lies within a table of n words
    function automatic logic in_table(input logic [7:0] a, input logic [7:0] base, input int n);
        in_table = (a >= base) && (a < 8'(base + 8'(n * 4))) && (a[1:0] == 2'b00);
    endfunction

    logic                               timer_access_enable;
    logic [NCH-1:0][7:0]                timer_irq_enable_reg;
    logic [NCH-1:0][SRC_W-1:0]          flag;
    logic [N_STORE-1:0][DATA_W-1:0]     prot_store;
    logic [N_BUF-1:0][DATA_W-1:0]       buf_store;
    logic [EVT_W-1:0]                   evt_stat;
    logic [EVT_W-1:0]                   evt_mask;
    logic [N_SHUT-1:0]                  shut_sync;
    logic                               shut_now;
    logic                               shut_prev;
    logic                               store_hit;
    logic                               buf_hit;
    logic                               prot_enable_hit;
    logic                               prot_hit;
    logic                               refused_wr;
    logic [DATA_W-1:0]                  next_rdata;
    logic [NCH-1:0][SRC_W-1:0]          pending;
    logic                               next_irq_any;
    logic [4:0]                         next_irq_top_id;

    // Address classes of the current access
    assign store_hit       = in_table(bus.addr, ADDR_PROT, N_STORE);
    assign buf_hit         = in_table(bus.addr, ADDR_BUF, N_BUF);
    assign prot_enable_hit = word_hit(bus.addr, ADDR_ENABLE, 3) || word_hit(bus.addr, ADDR_ENABLE, 4);
    assign prot_hit        = store_hit || prot_enable_hit;
    assign refused_wr      = bus.wr && prot_hit && !timer_access_enable;

    // Access-enable bit in the port timer write-enable register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_access_enable <= ACC_EN_RST;
        end else if (bus.wr && bus.addr == ADDR_ACCESS) begin
            timer_access_enable <= bus.wdata[BIT_ACC_EN];
        end
    end

    // Per-channel enables; channels 3 and 4 sit in the protected set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_irq_enable_reg <= {NCH{ENABLE_RST}};
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (bus.wr && word_hit(bus.addr, ADDR_ENABLE, c)
                    && (c < 3 || timer_access_enable)) begin
                    timer_irq_enable_reg[c] <= {bus.wdata[7:6],
                                                bus.wdata[5:0] & SRC_PRESENT[c*SRC_W +: SRC_W]};
                end
            end
        end
    end

    // Remaining protected registers: mode, control, io, counter, compare, output, gate, cycle, dead time
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prot_store <= {N_STORE{STORE_RST}};
        end else if (bus.wr && store_hit && timer_access_enable) begin
            prot_store[word_idx(bus.addr, ADDR_PROT)] <= bus.wdata;
        end
    end

    // Buffer registers ignore the access-enable bit, so reload data can be staged while locked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_store <= {N_BUF{STORE_RST}};
        end else if (bus.wr && buf_hit) begin
            buf_store[word_idx(bus.addr, ADDR_BUF)] <= bus.wdata;
        end
    end

    // Status flags: one cell per existing source; absent positions stay zero
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        for (genvar b = 0; b < SRC_W; b++) begin : g_src
            if (SRC_PRESENT[c*SRC_W + b]) begin : g_cell
                logic set_evt;
                logic rd_one;
                logic wr_zero;
                logic hw_clr;

                // Channel 4 folds underflow into its overflow flag
                if (c == 4 && b == BIT_OVF) begin : g_wrap
                    assign set_evt = src_evt[c].ovf | src_evt[c].unf;
                end else begin : g_plain
                    assign set_evt = src_evt[c][b];
                end

                assign rd_one  = bus.rd && word_hit(bus.addr, ADDR_STATUS, c) && flag[c][b];
                assign wr_zero = bus.wr && word_hit(bus.addr, ADDR_STATUS, c) && !bus.wdata[b];
                // Only compare A is cleared by the DMA controller
                assign hw_clr  = (b == BIT_CMP_A) ? dma_ack[c] : 1'b0;

                tirq_flag_cell u_flag (
                    .ref_clk (ref_clk),
                    .arst_n  (arst_n),
                    .set     (set_evt),
                    .rd_one  (rd_one),
                    .wr_zero (wr_zero),
                    .hw_clr  (hw_clr),
                    .flag    (flag[c][b])
                );
            end else begin : g_none
                assign flag[c][b] = 1'b0;
            end
        end
    end

    // Pending sources: flag and matching enable bit
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            pending[c] = flag[c] & timer_irq_enable_reg[c][SRC_W-1:0];
        end
    end

    // Highest pending source, channel 0 compare A first, channel 4 overflow last
    always_comb begin
        next_irq_any    = 1'b0;
        next_irq_top_id = 5'h1F;
        for (int c = NCH - 1; c >= 0; c--) begin
            for (int b = SRC_W - 1; b >= 0; b--) begin
                if (pending[c][b]) begin
                    next_irq_any    = 1'b1;
                    next_irq_top_id = 5'(c * SRC_W + b);
                end
            end
        end
    end

    // Request outputs as registered levels; they drop the cycle after the flag clears
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_req    <= '0;
            irq_any    <= 1'b0;
            irq_top_id <= 5'h1F;
        end else begin
            irq_req    <= pending;
            irq_any    <= next_irq_any;
            irq_top_id <= next_irq_top_id;
        end
    end

    // DMA and conversion-start requests come from compare A only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_req   <= '0;
            adc_start <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                dma_req[c]   <= flag[c][BIT_CMP_A] & timer_irq_enable_reg[c][BIT_DMA_SEL];
                adc_start[c] <= flag[c][BIT_CMP_A] & timer_irq_enable_reg[c][BIT_ADC_EN];
            end
        end
    end

    // Shutdown pins cross into this clock through three stages
    tirq_sync3 #(
        .W (N_SHUT)
    ) u_shut_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .din     (shutdown_pin),
        .dout    (shut_sync)
    );

    // Any input at its active level is enough; the pins are released when all go idle
    assign shut_now = |(shut_sync ^ {N_SHUT{~SHUT_ACTIVE}});

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_hiz   <= '0;
            shut_prev <= 1'b0;
        end else begin
            pwm_hiz   <= {N_PWM{shut_now}};
            shut_prev <= shut_now;
        end
    end

    // Block events: sticky, write one to clear, hardware set wins over the clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_stat <= '0;
        end else begin
            for (int i = 0; i < EVT_W; i++) begin
                if ((i == EVT_SHUT && shut_now && !shut_prev) || (i == EVT_REFUSED && refused_wr)) begin
                    evt_stat[i] <= 1'b1;
                end else if (bus.wr && bus.addr == ADDR_EVT_STAT && bus.wdata[i]) begin
                    evt_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Mask of block events
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_mask <= '0;
        end else if (bus.wr && bus.addr == ADDR_EVT_MASK) begin
            evt_mask <= bus.wdata[EVT_W-1:0];
        end
    end

    // Event interrupt: level while any unmasked event bit is set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_irq <= 1'b0;
        end else begin
            evt_irq <= |(evt_stat & evt_mask);
        end
    end

    // Read mux; locked protected words answer a fixed pattern rather than live contents
    always_comb begin
        next_rdata = '0;
        if (prot_hit && !timer_access_enable) begin
            next_rdata = UNDEF_READ;
        end else if (store_hit) begin
            next_rdata = prot_store[word_idx(bus.addr, ADDR_PROT)];
        end else if (buf_hit) begin
            next_rdata = buf_store[word_idx(bus.addr, ADDR_BUF)];
        end else if (bus.addr == ADDR_ACCESS) begin
            next_rdata[BIT_ACC_EN] = timer_access_enable;
        end else if (bus.addr == ADDR_EVT_STAT) begin
            next_rdata[EVT_W-1:0] = evt_stat;
        end else if (bus.addr == ADDR_EVT_MASK) begin
            next_rdata[EVT_W-1:0] = evt_mask;
        end else if (bus.addr == ADDR_SHUTDOWN) begin
            next_rdata[N_SHUT-1:0] = shut_sync;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (word_hit(bus.addr, ADDR_STATUS, c)) begin
                    next_rdata[SRC_W-1:0] = flag[c];
                end
                if (word_hit(bus.addr, ADDR_ENABLE, c)) begin
                    next_rdata[7:0] = timer_irq_enable_reg[c];
                end
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end
endmodule

// ===== bench/tirq_top_monitor.sv
// Concurrent checks on the ports of the timer event-request block
`timescale 1ns/100ps
module tirq_top_monitor
    import tirq_pkg::*;
(
    input wire logic                        ref_clk,
    input wire logic                        arst_n,
    input wire tirq_pkg::tirq_bus_t         bus,
    input wire tirq_pkg::tirq_src_t [4:0]   src_evt,
    input wire logic [tirq_pkg::NCH-1:0]    dma_ack,
    input wire logic [tirq_pkg::N_SHUT-1:0] shutdown_pin,
    input wire tirq_pkg::tirq_src_t [4:0]   irq_req,
    input wire logic                        irq_any,
    input wire logic [4:0]                  irq_top_id,
    input wire logic [tirq_pkg::NCH-1:0]    dma_req,
    input wire logic [tirq_pkg::N_PWM-1:0]  pwm_hiz
);
    logic [NCH-1:0] cmpa_evt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Compare-A event pulses gathered per channel
    always_comb for (int c = 0; c < NCH; c++) cmpa_evt[c] = src_evt[c].cmp[0];

    // Summary outputs follow the requests
    property p_any;
        irq_any == (|irq_req);
    endproperty
    a_any: assert property (p_any) else $error("summary request wrong");
    property p_none;
        !irq_any |-> irq_top_id == 5'h1F;
    endproperty
    a_none: assert property (p_none) else $error("top id without request");
    // A request falls only two cycles after a write or DMA service
    property p_drop;
        |($past(irq_req) & ~irq_req) |-> $past(bus.wr, 2) || $past(|dma_ack, 2);
    endproperty
    a_drop: assert property (p_drop) else $error("request dropped without clear");
    property p_absent;
        {irq_req[0].unf, irq_req[3].unf, irq_req[4].unf, irq_req[1].cmp[3:2], irq_req[2].cmp[3:2]} == 7'h00;
    endproperty
    a_absent: assert property (p_absent) else $error("absent source requested");
    property p_dma_rise;
        |(dma_req & ~$past(dma_req) & ~$past(cmpa_evt, 2)) |-> $past(bus.wr, 2);
    endproperty
    a_dma_rise: assert property (p_dma_rise) else $error("dma request without cause");
    property p_dma_clr;
        |(dma_ack & dma_req & ~cmpa_evt) |-> ##2 (dma_req & $past(dma_ack & ~cmpa_evt, 2)) == '0;
    endproperty
    a_dma_clr: assert property (p_dma_clr) else $error("dma service left request");
    // Pins settle inside seven cycles
    property p_shut_on;
        (shutdown_pin != 4'hF) [*7] |-> pwm_hiz == 6'h3F;
    endproperty
    a_shut_on: assert property (p_shut_on) else $error("pwm pins not forced");
    property p_shut_off;
        (shutdown_pin == 4'hF) [*7] |-> pwm_hiz == 6'h00;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("pwm pins held off");

    c_dma: cover property (|dma_ack);
    c_prio: cover property (irq_top_id == 5'd12);
    c_shut: cover property (pwm_hiz == 6'h3F);
endmodule

// ===== bench/tirq_far_model.sv
// Far side: DMA controller serving compare-A requests, A/D start counter
`timescale 1ns/100ps
module tirq_far_model
    import tirq_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire logic                     slow,
    input  wire logic [tirq_pkg::NCH-1:0] dma_req,
    input  wire logic [tirq_pkg::NCH-1:0] adc_start,
    output logic      [tirq_pkg::NCH-1:0] dma_ack,
    output logic      [7:0]               adc_cnt
);
    logic [NCH-1:0] req_prev;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] adc_prev;
    logic [3:0]     cnt;

    // Rising requests served at once or five cycles later, once per rise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_ack  <= '0;
            req_prev <= '0;
            pend     <= '0;
            cnt      <= 4'h0;
        end else begin
            req_prev <= dma_req;
            dma_ack  <= '0;
            if (pend != '0 && cnt >= (slow ? 4'h5 : 4'h0)) begin
                dma_ack <= pend & dma_req;
                pend    <= dma_req & ~req_prev;
                cnt     <= 4'h0;
            end else begin
                pend <= pend | (dma_req & ~req_prev);
                cnt  <= (pend != '0) ? cnt + 4'h1 : 4'h0;
            end
        end
    end

    // Conversion starts counted on each rising level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_prev <= '0;
            adc_cnt  <= 8'h00;
        end else begin
            adc_prev <= adc_start;
            adc_cnt  <= adc_cnt + 8'($countones(adc_start & ~adc_prev));
        end
    end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench of the timer event-request block
`timescale 1ns/100ps
module tb_top;
    import tirq_pkg::*;
    logic              ref_clk, arst_n, irq_any, evt_irq, slow;
    tirq_bus_t         bus;
    logic [DATA_W-1:0] rdata;
    tirq_src_t [4:0]   src_evt, irq_req;
    logic [NCH-1:0]    dma_ack, dma_req, adc_start;
    logic [N_SHUT-1:0] shutdown_pin;
    logic [4:0]        irq_top_id;
    logic [N_PWM-1:0]  pwm_hiz;
    logic [7:0]        adc_cnt;
    logic [5:0]        e;
    int                p, err_total, compares;

    tirq_top DUT (.ref_clk, .arst_n, .bus, .rdata, .src_evt, .dma_ack, .shutdown_pin, .irq_req, .irq_any,
        .irq_top_id, .dma_req, .adc_start, .pwm_hiz, .evt_irq);
    tirq_far_model u_far (.ref_clk, .arst_n, .slow, .dma_req, .adc_start, .dma_ack, .adc_cnt);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One-cycle write strobe; the slave never stalls
    task automatic wr(input logic [7:0] ad, input logic [15:0] wd);
        @(posedge ref_clk);
        bus <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input string nm, input logic [7:0] ad, input logic [15:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask
    task automatic evt(input int c, input int b);
        @(posedge ref_clk);
        src_evt[c][b] <= 1'b1;
        @(posedge ref_clk);
        src_evt[c][b] <= 1'b0;
    endtask
    function automatic logic [7:0] prot_addr(input int k);
        if (k < N_STORE) return 8'(ADDR_PROT + 4 * k);
        return (k == N_STORE) ? 8'h2C : 8'h30;
    endfunction
    task automatic finish_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs about 900 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    initial begin
        bus = '0; src_evt = '0; shutdown_pin = 4'hF; slow = 1'b0; arst_n = 1'b0;
        err_total = 0; compares = 0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdc("access_rst", ADDR_ACCESS, 16'h0001);
        // Each source: masked, enabled, unarmed clear ignored, armed clear
        for (int c = 0; c < NCH; c++) begin
            for (int b = 0; b < SRC_W; b++) begin
                p = (c == 4 && b == 5) ? 4 : b;
                e = (SRC_PRESENT[c * SRC_W + b] || p != b) ? 6'(1 << p) : 6'h00;
                wr(8'(ADDR_ENABLE + 4 * c), 16'h0000);
                evt(c, b);
                cyc(1);
                chk("irq_masked", irq_req[c], 32'h0);
                wr(8'(ADDR_ENABLE + 4 * c), 16'h003F);
                cyc(1);
                chk("irq_on", irq_req[c], e);
                chk("top_id", irq_top_id, (e != 0) ? 32'(c * SRC_W + p) : 32'h1F);
                wr(8'(ADDR_STATUS + 4 * c), 16'h0000);
                cyc(1);
                chk("irq_unarmed", irq_req[c], e);
                rdc("status", 8'(ADDR_STATUS + 4 * c), 16'(e));
                wr(8'(ADDR_STATUS + 4 * c), 16'h0000);
                cyc(1);
                chk("irq_clr", irq_req[c], 32'h0);
            end
        end
        // Fixed priority across pending sources
        for (int c = 0; c < NCH; c++) wr(8'(ADDR_ENABLE + 4 * c), 16'h003F);
        evt(4, 4);
        evt(2, 0);
        cyc(1);
        chk("top_id_a", irq_top_id, 32'd12);
        evt(0, 3);
        cyc(1);
        chk("top_id_b", irq_top_id, 32'd3);
        rdc("st0", ADDR_STATUS, 16'h0008);
        wr(ADDR_STATUS, 16'h0000);
        rdc("st2", 8'h08, 16'h0001);
        wr(8'h08, 16'h0000);
        rdc("st4", 8'h10, 16'h0010);
        wr(8'h10, 16'h0000);
        cyc(1);
        chk("irq_any", irq_any, 32'h0);
        // Far side serves compare A; software never writes zero meanwhile
        for (int c = 0; c < NCH; c++) begin
            slow <= c[0];
            wr(8'(ADDR_ENABLE + 4 * c), 16'h00C0);
            evt(c, 0);
            cyc(1);
            chk("dma_req", dma_req[c], 32'h1);
            chk("adc_start", adc_start[c], 32'h1);
            cyc(12);
            chk("dma_done", dma_req[c], 32'h0);
            chk("adc_cnt", adc_cnt, 32'(c + 1));
            rdc("flag_a", 8'(ADDR_STATUS + 4 * c), 16'h0000);
            wr(8'(ADDR_ENABLE + 4 * c), 16'h0000);
        end
        // Protected set locked: reads undefined, writes dropped, buffers open
        for (int k = 0; k < N_PROT; k++) wr(prot_addr(k), 16'(k + 1));
        wr(ADDR_ACCESS, 16'h0000);
        for (int k = 0; k < N_PROT; k++) begin
            rdc("locked_rd", prot_addr(k), UNDEF_READ);
            wr(prot_addr(k), 16'h00AA);
        end
        rdc("open_enable", ADDR_ENABLE, 16'h0000);
        for (int k = 0; k < N_BUF; k++) begin
            wr(8'(ADDR_BUF + 4 * k), 16'(16'h00B0 + k));
            rdc("buffer", 8'(ADDR_BUF + 4 * k), 16'(16'h00B0 + k));
        end
        rdc("refused", ADDR_EVT_STAT, 16'h0002);
        wr(ADDR_EVT_MASK, 16'h0003);
        cyc(1);
        chk("evt_irq_on", evt_irq, 32'h1);
        wr(ADDR_EVT_STAT, 16'h0002);
        cyc(1);
        chk("evt_irq_off", evt_irq, 32'h0);
        wr(ADDR_ACCESS, 16'h0001);
        for (int k = 0; k < N_PROT; k++) rdc("kept", prot_addr(k), 16'(k + 1));
        rdc("unmapped", 8'h50, 16'h0000);
        // Each shutdown pin alone forces all PWM pins off
        for (int i = 0; i < N_SHUT; i++) begin
            @(posedge ref_clk);
            shutdown_pin[i] <= 1'b0;
            cyc(8);
            chk("hiz_on", pwm_hiz, 32'h3F);
            chk("shut_irq", evt_irq, 32'h1);
            @(posedge ref_clk);
            shutdown_pin[i] <= 1'b1;
            cyc(8);
            chk("hiz_off", pwm_hiz, 32'h00);
            wr(ADDR_EVT_STAT, 16'h0001);
        end
        finish_test();
    end
endmodule

bind tirq_top tirq_top_monitor u_mon (.ref_clk, .arst_n, .bus, .src_evt, .dma_ack, .shutdown_pin, .irq_req,
    .irq_any, .irq_top_id, .dma_req, .pwm_hiz);
